// File: pmbus_status_consts.vh
// Constants for the PMBus status aggregation block: command codes, field positions, timing.
// Assumes a PMBus transaction layer outside that decodes commands into strobes.
// Summary of operation
// - Command DBh is answered only as a 7-byte block read and takes no write.
// - The 56-bit status block holds MFR, OTHER, CML, TEMPERATURE, INPUT, IOUT, VOUT from top down.
// - A write to a read-only command is an invalid-command fault and sets the CML bit of the status byte.
// - The same fault sets the invalid-command flag at bit 7 of the CML status byte.
// - The fault notifies the host by asserting the alert signal.
// - A write to command DBh never clears any asserted status bit.
// - Command DCh is a 2-byte word with read and write whose content depends on PHASE.
// - With PHASE at FFh or 80h a DCh read shows one bit per faulted phase.
// - With a single phase selected a DCh read shows bits 3..0 of own_fault_word, each gated by the same-numbered phase_enabled bit.
// - Bits of unassigned or disabled phases always read zero.
// - With PHASE at FFh or 80h bits 3..0 flag phases 3..0; bits 15:4 always read zero.
// - Command E3h accepts writes only while conversion is disabled, else it is read-only.
// - Each 4-bit delay field means 1 PWM clock for 0 and 2^N+1 PWM clocks for 1..15.
// - A power-good mask bit at 0 lets its event pull power good low, at 1 it blocks it.
`ifndef PMBUS_STATUS_CONSTS_VH
`define PMBUS_STATUS_CONSTS_VH
`define CMD_AGG_STATUS 8'hdb
`define CMD_PHASE_SUMMARY 8'hdc
`define CMD_PG_SETUP 8'he3
`define AGG_BYTES 3'h7
`define PHASE_ALL 8'hff
`define PHASE_ALL_ALT 8'h80
`define CML_INVALID_BIT 7
`define BYTE_CML_BIT 1
`define PG_ASSERT_DELAY_HI 15
`define PG_ASSERT_DELAY_LO 12
`define PG_RELEASE_DELAY_HI 11
`define PG_RELEASE_DELAY_LO 8
`define PG_SETUP_RESET 16'h0000
`define NUM_PHASES 4
`endif

// File: pg_delay_timer.v
// Power-good delay timer: counts PWM clock ticks for one delay field.
// Assumes pwm_tick is a one-cycle pulse per PWM clock, synchronous to sys_clk.
`timescale 1ns/1ps
`include "pmbus_status_consts.vh"
module pg_delay_timer (
  input wire sys_clk, // System clock
  input wire resetn, // Synchronous reset, active low
  input wire clk_en, // Clock enable
  input wire pwm_tick, // PWM clock tick
  input wire cond, // Condition being timed
  input wire [3:0] delay_code, // Delay field
  output reg expired // Condition held for the full delay
);
  reg [16:0] count_reg;
  wire [16:0] target;
  // 0 gives one tick, N gives 2^N+1 ticks
  assign target = (delay_code == 4'h0) ? 17'h00001 :
                  ((17'h00001 << delay_code) + 17'h00001);
  always @(posedge sys_clk) begin
    if (!resetn) begin
      count_reg <= 17'h00000;
      expired <= 1'b0;
    end else if (clk_en) begin
      if (!cond) begin
        count_reg <= 17'h00000;
        expired <= 1'b0;
      end else if (pwm_tick && !expired) begin
        count_reg <= count_reg + 17'h00001;
        if (count_reg + 17'h00001 >= target)
          expired <= 1'b1;
      end
    end
  end
endmodule // pg_delay_timer

// File: pmbus_status_aggregation.v
// PMBus status aggregation: STATUS block read, phase fault summary, power-good setup.
// Assumes an outside transaction layer gives command code, write/read strobes and word data.
`timescale 1ns/1ps
`include "pmbus_status_consts.vh"
module pmbus_status_aggregation (
  input wire sys_clk, // 200 MHz clock
  input wire resetn, // Synchronous reset, active low
  input wire clk_en, // Clock enable, freezes state when low
  input wire [7:0] cmd_code, // Command code of current transaction
  input wire cmd_write, // Write strobe, one cycle, data valid
  input wire [15:0] cmd_wdata, // Write data word
  input wire block_read_start, // Start of a block read, one cycle
  input wire byte_read, // Host takes next read byte, one cycle
  input wire word_read, // Word read request, one cycle
  input wire [7:0] phase_sel, // Current PHASE value
  input wire [3:0] phase_enabled, // Phase assigned and enabled per phase
  input wire [3:0] phase_faulted, // Fault seen per phase
  input wire [15:0] own_fault_word, // Faults seen by the selected phase
  input wire [7:0] status_mfr, // Status byte MFR
  input wire [7:0] status_other, // Status byte OTHER
  input wire [7:0] status_cml_in, // CML bits from other sources
  input wire [7:0] status_temp, // Status byte TEMPERATURE
  input wire [7:0] status_input, // Status byte INPUT
  input wire [7:0] status_iout, // Status byte IOUT
  input wire [7:0] status_vout, // Status byte VOUT
  input wire cml_clear, // Host clears CML status, one cycle
  input wire conversion_en, // Conversion enabled
  input wire pwm_tick, // PWM clock tick
  input wire [7:0] pg_events, // Fault/warning events in mask bit order
  output reg [7:0] rdata, // Read byte / block byte
  output reg [15:0] rword, // Read word
  output reg rvalid, // Read data valid, one cycle
  output reg [7:0] status_cml_out, // Held CML status byte
  output reg cml_summary, // CML bit of status byte
  output reg alert_out, // Alert to host, active high
  output reg [15:0] power_good_setup, // Setup register
  output reg power_good_output // Power good level
);
  reg [55:0] snap_reg;
  reg [2:0] byte_cnt_reg;
  reg block_active_reg;
  reg [7:0] cml_flags_reg;
  reg pg_bad_reg;
  wire [55:0] live_status;
  wire is_ro_write;
  wire [3:0] phase_bits;
  wire [15:0] summary_word;
  wire [7:0] unmasked;
  wire any_event;
  wire off_done;
  wire on_done;
  wire [7:0] cml_full;

  assign cml_full = cml_flags_reg | status_cml_in;
  assign live_status = {status_mfr, status_other, cml_full, status_temp,
                        status_input, status_iout, status_vout};

  // DBh takes no write; E3h is read-only while converting
  assign is_ro_write = cmd_write && ((cmd_code == `CMD_AGG_STATUS) ||
                       ((cmd_code == `CMD_PG_SETUP) && conversion_en));

  genvar i;
  generate
    for (i = 0; i < `NUM_PHASES; i = i + 1) begin : g_phase
      assign phase_bits[i] = phase_enabled[i] &
        (((phase_sel == `PHASE_ALL) || (phase_sel == `PHASE_ALL_ALT)) ?
         phase_faulted[i] : own_fault_word[i]);
    end
  endgenerate
  assign summary_word = {12'h000, phase_bits};

  assign unmasked = pg_events & ~power_good_setup[7:0];
  assign any_event = |unmasked;

  pg_delay_timer u_off (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .pwm_tick(pwm_tick),
    .cond(any_event),
    .delay_code(power_good_setup[`PG_ASSERT_DELAY_HI:`PG_ASSERT_DELAY_LO]),
    .expired(off_done)
  );
  pg_delay_timer u_on (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .pwm_tick(pwm_tick),
    .cond(!any_event),
    .delay_code(power_good_setup[`PG_RELEASE_DELAY_HI:`PG_RELEASE_DELAY_LO]),
    .expired(on_done)
  );

  always @(posedge sys_clk) begin
    if (!resetn) begin
      snap_reg <= 56'h00000000000000;
      byte_cnt_reg <= 3'h0;
      block_active_reg <= 1'b0;
      cml_flags_reg <= 8'h00;
      pg_bad_reg <= 1'b0;
      rdata <= 8'h00;
      rword <= 16'h0000;
      rvalid <= 1'b0;
      status_cml_out <= 8'h00;
      cml_summary <= 1'b0;
      alert_out <= 1'b0;
      power_good_setup <= `PG_SETUP_RESET;
      power_good_output <= 1'b0;
    end else if (clk_en) begin
      rvalid <= 1'b0;
      // Block read: snapshot so all seven bytes agree
      if (block_read_start && cmd_code == `CMD_AGG_STATUS) begin
        snap_reg <= live_status;
        block_active_reg <= 1'b1;
        byte_cnt_reg <= 3'h0;
        rdata <= {5'h00, `AGG_BYTES}; // byte count first
        rvalid <= 1'b1;
      end else if (byte_read && block_active_reg) begin
        // MFR byte first, VOUT last
        rdata <= snap_reg[55:48];
        snap_reg <= {snap_reg[47:0], 8'h00};
        rvalid <= 1'b1;
        byte_cnt_reg <= byte_cnt_reg + 3'h1;
        if (byte_cnt_reg == `AGG_BYTES - 3'h1)
          block_active_reg <= 1'b0;
      end
      if (word_read) begin
        rvalid <= 1'b1;
        if (cmd_code == `CMD_PHASE_SUMMARY)
          rword <= summary_word;
        else if (cmd_code == `CMD_PG_SETUP)
          rword <= power_good_setup;
        else
          rword <= 16'h0000;
      end
      // Phase summary writes are accepted but hold no state of their own
      if (cmd_write && cmd_code == `CMD_PG_SETUP && !conversion_en)
        power_good_setup <= cmd_wdata;
      // Set wins over clear; a DBh write never clears anything
      if (is_ro_write) begin
        cml_flags_reg[`CML_INVALID_BIT] <= 1'b1;
      end else if (cml_clear) begin
        cml_flags_reg <= 8'h00;
      end
      status_cml_out <= cml_full;
      cml_summary <= (|cml_full) | is_ro_write;
      alert_out <= (|cml_full) | is_ro_write;
      // Power good held low while converter is off
      if (!conversion_en)
        pg_bad_reg <= 1'b1;
      else if (off_done)
        pg_bad_reg <= 1'b1;
      else if (on_done)
        pg_bad_reg <= 1'b0;
      power_good_output <= conversion_en && !pg_bad_reg && !off_done;
    end
  end
endmodule // pmbus_status_aggregation

// File: pmbus_status_aggregation_chk.sv
// Checker: port-level assertions for the PMBus status aggregation block.
// Assumes it is bound to the design top and sees only that module's ports.
`timescale 1ns/1ps
module pmbus_status_aggregation_chk (
  input wire sys_clk, // Clock
  input wire resetn, // Reset, active low
  input wire clk_en, // Clock enable
  input wire [7:0] cmd_code, // Command code
  input wire cmd_write, // Write strobe
  input wire block_read_start, // Block read start
  input wire word_read, // Word read strobe
  input wire [7:0] phase_sel, // Selected phase
  input wire [3:0] phase_enabled, // Enabled phases
  input wire [3:0] phase_faulted, // Faulted phases
  input wire cml_clear, // CML clear
  input wire conversion_en, // Conversion enabled
  input wire [7:0] rdata, // Read byte
  input wire [15:0] rword, // Read word
  input wire rvalid, // Read valid
  input wire [7:0] status_cml_out, // Held CML byte
  input wire cml_summary, // CML summary bit
  input wire alert_out, // Alert
  input wire [15:0] power_good_setup // Setup word
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire bad_wr = clk_en && cmd_write && cmd_code == 8'hdb;
  a_block_count: assert property (clk_en && block_read_start && cmd_code == 8'hdb |=>
    rvalid && rdata == 8'h07) else $error("block count byte wrong");
  a_word_answer: assert property (clk_en && word_read |=> rvalid)
    else $error("word read not answered");
  a_bad_summary: assert property (bad_wr |=> cml_summary) else $error("cml summary not set");
  a_bad_alert: assert property (bad_wr |=> alert_out) else $error("alert not raised");
  a_bad_flag: assert property (bad_wr ##1 !cml_clear |-> ##1 status_cml_out[7])
    else $error("invalid command flag not set");
  a_no_clear: assert property (bad_wr && !cml_clear && !$past(cml_clear) && status_cml_out[7]
    |=> status_cml_out[7]) else $error("status write cleared a flag");
  a_phase_map: assert property (clk_en && word_read && cmd_code == 8'hdc && phase_sel == 8'hff
    |=> rword == {12'h000, $past(phase_faulted) & $past(phase_enabled)})
    else $error("phase summary wrong");
  a_setup_lock: assert property (clk_en && cmd_write && cmd_code == 8'he3 && conversion_en
    |=> $stable(power_good_setup)) else $error("setup written while converting");
  c_block: cover property (clk_en && block_read_start && cmd_code == 8'hdb);
  c_bad: cover property (bad_wr);
  c_lock: cover property (clk_en && cmd_write && cmd_code == 8'he3 && conversion_en);
endmodule // pmbus_status_aggregation_chk
bind pmbus_status_aggregation pmbus_status_aggregation_chk i_chk (.sys_clk, .resetn, .clk_en,
  .cmd_code, .cmd_write, .block_read_start, .word_read, .phase_sel, .phase_enabled,
  .phase_faulted, .cml_clear, .conversion_en, .rdata, .rword, .rvalid, .status_cml_out,
  .cml_summary, .alert_out, .power_good_setup);

// File: pmbus_host_model.sv
// PMBus host model: issues decoded command strobes and collects answers.
// Assumes strobes are taken on the rising edge and answered at that same edge.
`timescale 1ns/1ps
module pmbus_host_model (
  input wire sys_clk, // Clock
  input wire [7:0] rdata, // Read byte
  input wire [15:0] rword, // Read word
  input wire rvalid, // Read valid
  output reg [7:0] cmd_code = 8'h00, // Command code
  output reg cmd_write = 1'b0, // Write strobe
  output reg [15:0] cmd_wdata = 16'h0000, // Write data
  output reg block_read_start = 1'b0, // Block start
  output reg byte_read = 1'b0, // Next block byte
  output reg word_read = 1'b0 // Word read
);
  // Kind 0 write, 1 word read, 2 block start, 3 block byte
  // The answer is registered at the edge that takes the strobe, so it is read just after it
  task go(input [7:0] c, input [1:0] k, input [15:0] d, output [15:0] r);
    begin
      @(negedge sys_clk);
      cmd_code = c;
      cmd_wdata = d;
      {byte_read, block_read_start, word_read, cmd_write} = 4'b0001 << k;
      r = 16'hxxxx;
      @(posedge sys_clk);
      #1;
      if (k != 0 && rvalid === 1'b1)
        r = (k == 1) ? rword : {8'h00, rdata};
      @(negedge sys_clk);
      {byte_read, block_read_start, word_read, cmd_write} = 4'b0000;
    end
  endtask
endmodule // pmbus_host_model

// File: tb_pmbus_status_aggregation.sv
// Testbench for the PMBus status aggregation block.
// Assumes the host model drives command strobes; status inputs come from here.
`timescale 1ns/1ps
module tb_pmbus_status_aggregation;
  reg sys_clk = 0, resetn = 0, clk_en = 1, cml_clear = 0, conversion_en = 0, pwm_tick = 0;
  reg [7:0] phase_sel = 0, pg_events = 0, status_mfr = 0, status_other = 0, status_cml_in = 0;
  reg [7:0] status_temp = 0, status_input = 0, status_iout = 0, status_vout = 0;
  reg [3:0] phase_enabled = 0, phase_faulted = 0;
  reg [15:0] own_fault_word = 0, r;
  reg [55:0] exp_blk = 56'h11223344556677;
  integer errors = 0, checks_done = 0, i;
  wire [7:0] cmd_code, rdata, status_cml_out;
  wire [15:0] cmd_wdata, rword, power_good_setup;
  wire cmd_write, block_read_start, byte_read, word_read, rvalid, cml_summary, alert_out;
  wire power_good_output;
  initial forever #2.5 sys_clk = ~sys_clk;
  always @(negedge sys_clk) pwm_tick = ~pwm_tick;
  pmbus_host_model h (.sys_clk, .rdata, .rword, .rvalid, .cmd_code, .cmd_write, .cmd_wdata,
    .block_read_start, .byte_read, .word_read);
  pmbus_status_aggregation i_dut (.sys_clk, .resetn, .clk_en, .cmd_code, .cmd_write,
    .cmd_wdata, .block_read_start, .byte_read, .word_read, .phase_sel, .phase_enabled,
    .phase_faulted, .own_fault_word, .status_mfr, .status_other, .status_cml_in, .status_temp,
    .status_input, .status_iout, .status_vout, .cml_clear, .conversion_en, .pwm_tick,
    .pg_events, .rdata, .rword, .rvalid, .status_cml_out, .cml_summary, .alert_out,
    .power_good_setup, .power_good_output);
  task chk(input string n, input [15:0] e, input [15:0] s);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("unexpected %0s expected %h seen %h", n, e, s);
    end
  endtask
  task t_block;
    @(negedge sys_clk);
    {status_mfr, status_other, status_cml_in, status_temp, status_input, status_iout,
      status_vout} = exp_blk;
    h.go(8'hdb, 2, 0, r); chk("block count", 16'h0007, r);
    @(negedge sys_clk) status_vout = 8'h00; // Late change must not reach this block
    for (i = 0; i < 7; i++) begin
      h.go(8'hdb, 3, 0, r); chk("block byte", {8'h00, exp_blk[55 - 8 * i -: 8]}, r);
    end
  endtask
  task t_bad;
    @(negedge sys_clk) status_cml_in = 8'h00;
    repeat (2) @(negedge sys_clk);
    chk("cml idle", 16'h0000, {15'h0, cml_summary});
    h.go(8'hdb, 0, 16'h0000, r);
    h.go(8'hdb, 0, 16'hffff, r);
    @(posedge sys_clk) #1;
    chk("cml summary", 16'h0001, {15'h0, cml_summary});
    chk("cml flag", 16'h0001, {15'h0, status_cml_out[7]});
    chk("alert", 16'h0001, {15'h0, alert_out});
    @(negedge sys_clk) status_cml_in = 8'h00;
    cml_clear = 1;
    @(negedge sys_clk) cml_clear = 0;
    repeat (3) @(posedge sys_clk);
    #1 chk("cleared", 16'h0000, {status_cml_out[7], alert_out});
  endtask
  task t_phase;
    @(negedge sys_clk) {phase_enabled, phase_faulted, own_fault_word} = 24'hbffff5;
    for (i = 0; i < 2; i++) begin
      @(negedge sys_clk) phase_sel = i ? 8'h80 : 8'hff;
      h.go(8'hdc, 1, 0, r); chk("phase map", 16'h000b, r);
    end
    @(negedge sys_clk) {phase_sel, phase_enabled} = {8'h02, 4'hf};
    h.go(8'hdc, 1, 0, r); chk("phase own", 16'h0005, r);
    h.go(8'hdc, 0, 16'h000a, r);
    h.go(8'hdc, 1, 0, r); chk("phase after write", 16'h0005, r);
  endtask
  task t_setup;
    h.go(8'he3, 0, 16'h5a3c, r);
    h.go(8'he3, 1, 0, r); chk("setup open", 16'h5a3c, r);
    @(negedge sys_clk) conversion_en = 1;
    h.go(8'he3, 0, 16'h1234, r);
    h.go(8'he3, 1, 0, r); chk("setup locked", 16'h5a3c, r);
    chk("setup port", 16'h5a3c, power_good_setup);
    chk("refused flag", 16'h0001, {15'h0, status_cml_out[7]});
    repeat (50) @(negedge sys_clk);
    chk("power good up", 16'h0001, {15'h0, power_good_output});
    pg_events = 8'h3c;
    repeat (100) @(negedge sys_clk);
    chk("power good masked", 16'h0001, {15'h0, power_good_output});
    pg_events = 8'h40;
    repeat (20) @(negedge sys_clk);
    chk("power good early", 16'h0001, {15'h0, power_good_output});
    repeat (60) @(negedge sys_clk);
    chk("power good low", 16'h0000, {15'h0, power_good_output});
  endtask
  task end_of_test;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #20000;
    errors++;
    end_of_test;
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk) resetn = 1;
    t_block;
    t_bad;
    t_phase;
    t_setup;
    end_of_test;
  end
endmodule // tb_pmbus_status_aggregation
